/* File: hw/dgs_pkg.sv */
package dgs_pkg;

    // ************************************************************
    // Microinstruction layout
    // ************************************************************
    localparam int UI_W        = 20;
    localparam int ADDR_W      = 6;
    localparam int SEL_W       = 3;
    localparam int RES_W       = 2;
    localparam int RASTER_W    = 8;
    localparam int PROG_DEPTH  = 64;
    localparam int NUM_PROGS   = 3;

    // Select codes shared by both selectors
    localparam logic [2:0] SEL_ZERO = 3'h0;
    localparam logic [2:0] SEL_ONE  = 3'h7;

    // Cycle opcodes to the timing generator
    localparam logic [1:0] OP_REFRESH = 2'h0;
    localparam logic [1:0] OP_READ    = 2'h1;
    localparam logic [1:0] OP_WRITE   = 2'h2;
    localparam logic [1:0] OP_NOP     = 2'h3;

    localparam logic [5:0] DMA_READBACK_STEP = 6'h32;

    typedef struct packed {
        logic [5:0] next_address_field;
        logic [2:0] second_condition_select;
        logic [2:0] first_condition_select;
        logic       shift;
        logic       x_update;
        logic       y_update;
        logic       fg_load;
        logic       bus_write;
        logic       bus_ack;
        logic       ready;
        logic [1:0] opcode;
    } dgs_uinst_t;

    typedef struct packed {
        logic quasi_dma_active;
        logic hold_read_update;
        logic move_write_addressed;
        logic generator_dma_active;
        logic bus_read_or_write;
        logic bus_write_in;
    } dgs_cond2_t;

    typedef struct packed {
        logic operation_pending;
        logic generator_is_dma_source;
        logic valid_programmed_transfer;
        logic move_register_addressed;
        logic update_only;
        logic cycle_complete;
    } dgs_cond1_t;

endpackage

/* File: hw/dgs_sequencer.sv */
`timescale 1ns/10ps
module dgs_sequencer
    import dgs_pkg::*;
#(
    parameter int DATA_W = 16
) (
    input  wire logic                core_clk_i,
    input  wire logic                reset_i,
    input  wire logic [RES_W-1:0]    resolution_key_i,
    input  wire dgs_cond2_t          cond2_i,
    input  wire dgs_cond1_t          cond1_i,
    input  wire logic [DATA_W-1:0]   internal_data_i,
    input  wire logic                raster_register_load_strobe_i,
    input  wire logic                ucode_wr_i,
    input  wire logic [RES_W-1:0]    ucode_wr_prog_i,
    input  wire logic [ADDR_W-1:0]   ucode_wr_addr_i,
    input  wire dgs_uinst_t          ucode_wr_data_i,
    output logic                     shift_pulse_o,
    output logic                     x_point_update_pulse_o,
    output logic                     y_point_update_pulse_o,
    output logic                     foreground_load_pulse_o,
    output logic                     generator_bus_write_o,
    output logic                     generator_bus_ack_o,
    output logic                     force_ready_out_o,
    output logic [1:0]               cycle_opcode_o,
    output logic                     memory_readback_line_o,
    output logic [RASTER_W-1:0]      raster_data_o,
    output logic                     raster_bit_o,
    output logic [ADDR_W-1:0]        uaddr_o
);

    // ************************************************************
    // Microcode store: one 64-word program per resolution
    // ************************************************************
    dgs_uinst_t ucode_mem [NUM_PROGS*PROG_DEPTH];

    logic [ADDR_W-1:0]   uaddr_r;
    logic [ADDR_W-1:0]   uaddr_nxt;
    dgs_uinst_t          uinst_r;
    logic [RES_W-1:0]    prog_sel_r;
    logic [RASTER_W-1:0] raster_r;
    logic [RASTER_W-1:0] raster_nxt;

    wire logic [7:0] fetch_idx = {prog_sel_r, uaddr_nxt};
    wire logic [7:0] wr_idx    = {ucode_wr_prog_i, ucode_wr_addr_i};

    // Write port; words aimed at an unused program are dropped
    always_ff @(posedge core_clk_i) begin
        if (ucode_wr_i && (ucode_wr_prog_i < RES_W'(NUM_PROGS))) begin
            ucode_mem[wr_idx] <= ucode_wr_data_i;
        end
    end

    // Program select follows a used key on every clock out of reset; reset clears it to 0
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            prog_sel_r <= '0;
        end else if (resolution_key_i < RES_W'(NUM_PROGS)) begin
            prog_sel_r <= resolution_key_i;
        end
    end

    // ************************************************************
    // Condition selectors
    // ************************************************************
    logic [7:0] sel2_vec;
    logic [7:0] sel1_vec;
    assign sel2_vec = {1'b1, cond2_i.bus_write_in, cond2_i.bus_read_or_write,
                       cond2_i.generator_dma_active, cond2_i.move_write_addressed,
                       cond2_i.hold_read_update, cond2_i.quasi_dma_active, 1'b0};
    assign sel1_vec = {1'b1, cond1_i.cycle_complete, cond1_i.update_only,
                       cond1_i.move_register_addressed,
                       cond1_i.valid_programmed_transfer,
                       cond1_i.generator_is_dma_source,
                       cond1_i.operation_pending, 1'b0};

    wire logic cond2_bit = sel2_vec[uinst_r.second_condition_select];
    wire logic cond1_bit = sel1_vec[uinst_r.first_condition_select];

    // Group of four chosen by next-address, low pair by conditions
    assign uaddr_nxt = {uinst_r.next_address_field[5:2], cond2_bit, cond1_bit};

    // ************************************************************
    // Sequencer: one microword per clock
    // ************************************************************
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            uaddr_r <= '0;
            uinst_r <= '{next_address_field: 6'h00,
                         second_condition_select: SEL_ZERO,
                         first_condition_select: SEL_ZERO,
                         opcode: OP_NOP, default: 1'b0};
        end else begin
            uaddr_r <= uaddr_nxt;
            uinst_r <= ucode_mem[fetch_idx];
        end
    end

    // ************************************************************
    // Raster data register
    // ************************************************************
    always_comb begin
        raster_nxt = raster_r;
        if (raster_register_load_strobe_i) begin
            raster_nxt = internal_data_i[RASTER_W-1:0];
        end else if (uinst_r.shift) begin
            raster_nxt = {raster_r[RASTER_W-2:0], raster_r[RASTER_W-1]};
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            raster_r <= '0;
        end else begin
            raster_r <= raster_nxt;
        end
    end

    // ************************************************************
    // Control outputs straight from the microword register, readback line decoded from its opcode; raster and address outputs from their own registers
    // ************************************************************
    assign shift_pulse_o           = uinst_r.shift;
    assign x_point_update_pulse_o  = uinst_r.x_update;
    assign y_point_update_pulse_o  = uinst_r.y_update;
    assign foreground_load_pulse_o = uinst_r.fg_load;
    assign generator_bus_write_o   = uinst_r.bus_write;
    assign generator_bus_ack_o     = uinst_r.bus_ack;
    assign force_ready_out_o       = uinst_r.ready;
    assign cycle_opcode_o          = uinst_r.opcode;
    assign memory_readback_line_o  = (uinst_r.opcode == OP_READ);
    assign raster_data_o           = raster_r;
    assign raster_bit_o            = raster_r[RASTER_W-1];
    assign uaddr_o                 = uaddr_r;

    // ************************************************************
    // Checks
    // ************************************************************
    chk_zero_select: assert property (@(posedge core_clk_i) disable iff (reset_i)
        uinst_r.first_condition_select == SEL_ZERO && uinst_r.second_condition_select == SEL_ZERO
        |=> uaddr_r[1:0] == 2'h0)
        else $error("zero select did not force low address bits");
    chk_one_select: assert property (@(posedge core_clk_i) disable iff (reset_i)
        uinst_r.first_condition_select == SEL_ONE && uinst_r.second_condition_select == SEL_ONE
        |=> uaddr_r[1:0] == 2'h3)
        else $error("one select did not force low address bits");
    chk_group_branch: assert property (@(posedge core_clk_i) disable iff (reset_i)
        1'b1 |=> uaddr_r[5:2] == $past(uinst_r.next_address_field[5:2]))
        else $error("branch left its four-word group");
    chk_shift_rotate: assert property (@(posedge core_clk_i) disable iff (reset_i)
        uinst_r.shift && !raster_register_load_strobe_i
        |=> raster_r == {$past(raster_r[6:0]), $past(raster_r[7])})
        else $error("raster register did not rotate left");
    chk_raster_load: assert property (@(posedge core_clk_i) disable iff (reset_i)
        raster_register_load_strobe_i |=> raster_r == $past(internal_data_i[7:0]))
        else $error("raster register did not load low byte");
    chk_raster_hold: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !uinst_r.shift && !raster_register_load_strobe_i |=> $stable(raster_r))
        else $error("raster register moved without shift");
    chk_readback_line: assert property (@(posedge core_clk_i) disable iff (reset_i)
        memory_readback_line_o == (cycle_opcode_o == 2'h1))
        else $error("readback line disagrees with opcode");
    chk_wait_loop: assert property (@(posedge core_clk_i) disable iff (reset_i)
        uinst_r.next_address_field[5:2] == uaddr_r[5:2]
        && uinst_r.first_condition_select == SEL_ONE
        && uinst_r.second_condition_select == SEL_ONE && uaddr_r[1:0] == 2'h3
        |=> uaddr_r == $past(uaddr_r))
        else $error("self loop did not repeat");
    chk_reset_nop: assert property (@(posedge core_clk_i)
        reset_i |=> cycle_opcode_o == 2'h3 && !force_ready_out_o)
        else $error("opcode not no-operation after reset");

    // ************************************************************
    // Branch and program select checks
    // ************************************************************
    // Select codes that the checks below watch directly
    localparam logic [2:0] SEL_QUASI_DMA  = 3'h1;
    localparam logic [2:0] SEL_CYCLE_DONE = 3'h6;

    chk_quasi_branch: assert property (@(posedge core_clk_i) disable iff (reset_i)
        uinst_r.second_condition_select == SEL_QUASI_DMA
        |=> uaddr_r[1] == $past(cond2_i.quasi_dma_active))
        else $error("second selector missed the quasi-DMA flag");
    chk_complete_branch: assert property (@(posedge core_clk_i) disable iff (reset_i)
        uinst_r.first_condition_select == SEL_CYCLE_DONE
        |=> uaddr_r[0] == $past(cond1_i.cycle_complete))
        else $error("first selector missed cycle complete");
    chk_readback_wait: assert property (@(posedge core_clk_i) disable iff (reset_i)
        uaddr_r == DMA_READBACK_STEP && !cond1_i.cycle_complete
        |=> uaddr_r == DMA_READBACK_STEP)
        else $error("readback step left before cycle complete");
    chk_key_follow: assert property (@(posedge core_clk_i) disable iff (reset_i)
        resolution_key_i < RES_W'(NUM_PROGS) |=> prog_sel_r == $past(resolution_key_i))
        else $error("program select did not follow the key");
    chk_key_refused: assert property (@(posedge core_clk_i) disable iff (reset_i)
        resolution_key_i >= RES_W'(NUM_PROGS) |=> $stable(prog_sel_r))
        else $error("program select took an unused key");

    cov_readback: cover property (@(posedge core_clk_i) disable iff (reset_i)
        uaddr_r == DMA_READBACK_STEP ##1 uaddr_r == DMA_READBACK_STEP);
    cov_shift: cover property (@(posedge core_clk_i) disable iff (reset_i) shift_pulse_o);
    cov_write: cover property (@(posedge core_clk_i) disable iff (reset_i)
        cycle_opcode_o == OP_WRITE);
    cov_ready: cover property (@(posedge core_clk_i) disable iff (reset_i) force_ready_out_o);
    cov_key_refused: cover property (@(posedge core_clk_i) disable iff (reset_i)
        resolution_key_i >= RES_W'(NUM_PROGS));

endmodule

/* File: dv/dgs_timing_model.sv */
`timescale 1ns/10ps
module dgs_timing_model
    import dgs_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    input  wire logic [1:0] cycle_opcode_i,
    input  wire logic [3:0] lat_i,
    output logic            cycle_complete_o
);
    logic [3:0] cnt_r;
    logic       busy;
    assign busy = (cycle_opcode_i == OP_READ) || (cycle_opcode_i == OP_WRITE);
    // Count cycles of a memory request; completion shows once the latency is reached
    always_ff @(posedge core_clk_i) begin
        if (reset_i || !busy) begin
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end
    assign cycle_complete_o = busy && (cnt_r == lat_i);
endmodule

/* File: dv/display_generator_sequencer_tb_top.sv */
`timescale 1ns/10ps
module display_generator_sequencer_tb_top;
    import dgs_pkg::*;
    logic        clk, rst, ld, uwr, cc, sh, xu, yu, fg, bw, ba, rdy, rb, rbit;
    logic [1:0]  key, uprog, op;
    logic [5:0]  c2, c1, uad, ua;
    logic [15:0] data;
    logic [3:0]  lat;
    logic [7:0]  rd;
    dgs_uinst_t  uw;
    int          num_errors, checked, cyc;
    logic [6:0]  fl;
    logic [6:0]  fpat [3];
    assign fl = {sh, xu, yu, fg, bw, ba, rdy};
    dgs_sequencer u_dgs_sequencer (.core_clk_i(clk), .reset_i(rst), .resolution_key_i(key),
        .cond2_i(dgs_cond2_t'(c2)), .cond1_i(dgs_cond1_t'(c1 | {5'h00, cc})),
        .internal_data_i(data), .raster_register_load_strobe_i(ld), .ucode_wr_i(uwr),
        .ucode_wr_prog_i(uprog), .ucode_wr_addr_i(uad), .ucode_wr_data_i(uw),
        .shift_pulse_o(sh), .x_point_update_pulse_o(xu), .y_point_update_pulse_o(yu),
        .foreground_load_pulse_o(fg), .generator_bus_write_o(bw), .generator_bus_ack_o(ba),
        .force_ready_out_o(rdy), .cycle_opcode_o(op), .memory_readback_line_o(rb),
        .raster_data_o(rd), .raster_bit_o(rbit), .uaddr_o(ua));
    dgs_timing_model u_dgs_timing_model (.core_clk_i(clk), .reset_i(rst),
        .cycle_opcode_i(op), .lat_i(lat), .cycle_complete_o(cc));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            results();
        end
    end
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic results;
        if (num_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [1:0] p, input logic [5:0] a, input logic [5:0] nx,
                      input logic [2:0] s2, input logic [2:0] s1, input logic [6:0] f,
                      input logic [1:0] o);
        uwr = 1'b1;
        uprog = p;
        uad = a;
        uw = {nx, s2, s1, f, o};
        tick(1);
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {ld, uwr, c2, c1, key, uprog, uad, data, uw} = '0;
        rst = 1'b1;
        lat = 4'h0;
        fpat = '{7'h6d, 7'h5b, 7'h76};
        tick(10);
        chk("opcode", op, OP_NOP);
        chk("flags", fl, 7'h00);
        chk("readback", rb, 1'b0);
        for (int a = 4; a < 8; a++) begin
            wr(2'h0, a[5:0], 6'h04, 3'h7, 3'h7, 7'h00, OP_NOP);
        end
        for (int k = 0; k < 16; k++) begin
            rst = 1'b1;
            wr(2'h0, 6'h00, 6'h04, k[2:0], k[2:0], 7'h00, OP_NOP);
            uwr = 1'b0;
            c2 = (!k[3] && k[2:0] != 0 && k[2:0] != 7) ? 6'h20 >> (k[2:0] - 1) : 6'h00;
            c1 = (k[3] && k[2:0] != 0 && k[2:0] != 7) ? 6'h20 >> (k[2:0] - 1) : 6'h00;
            rst = 1'b0;
            tick(2);
            chk("select", ua, {4'h1, k[2:0] == 7 || (!k[3] && k[2:0] != 0),
                k[2:0] == 7 || (k[3] && k[2:0] != 0)});
            tick(3);
            chk("selfloop", ua, 6'h07);
        end
        rst = 1'b1;
        for (int p = 0; p < 3; p++) begin
            wr(p[1:0], 6'h00, 6'h00, 3'h0, 3'h1, 7'h00, OP_NOP);
            wr(p[1:0], 6'h01, 6'h30, 3'h7, 3'h0, fpat[p], OP_NOP);
            wr(p[1:0], 6'h32, 6'h30, 3'h7, 3'h6, 7'h00, OP_READ);
            wr(p[1:0], 6'h33, 6'h00, 3'h0, 3'h0, 7'h00, OP_WRITE);
        end
        uwr = 1'b0;
        for (int p = 0; p < 3; p++) begin
            rst = 1'b1;
            key = p[1:0];
            lat = p ? 4'h4 : 4'h0;
            c1 = 6'h00;
            tick(1);
            rst = 1'b0;
            tick(3);
            chk("idle", ua, 6'h00);
            key = 2'h3;
            ld = 1'b1;
            data = 16'hff81;
            tick(1);
            ld = 1'b0;
            chk("raster", rd, 8'h81);
            c1 = 6'h20;
            tick(1);
            c1 = 6'h00;
            chk("step", ua, 6'h01);
            chk("flags", fl, fpat[p]);
            tick(1);
            chk("readstep", ua, DMA_READBACK_STEP);
            chk("rotate", rd, 8'h03);
            chk("rasterbit", rbit, 1'b0);
            chk("opcode", op, OP_READ);
            chk("readback", rb, 1'b1);
            for (int i = 0; i < lat; i++) begin
                tick(1);
                chk("hold", ua, DMA_READBACK_STEP);
            end
            tick(1);
            chk("advance", ua, 6'h33);
            chk("opcode", op, OP_WRITE);
            chk("readback", rb, 1'b0);
            chk("flags", fl, 7'h00);
        end
        results();
    end
endmodule
